/* File: pkg/swb_pkg.sv */
// Constants, carriers and helpers shared by the subtract-with-borrow unit
package swb_pkg;

  // --------------------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // --------------------------------------------------------------------------
  localparam int          SWB_ADDR_W     = 12;
  localparam logic [11:0] SWB_OFF_INSTR  = 12'h000;
  localparam logic [11:0] SWB_OFF_STATUS = 12'h004;
  localparam logic [11:0] SWB_OFF_RESULT = 12'h008;
  localparam logic [11:0] SWB_OFF_ERROR  = 12'h00C;
  localparam logic [11:0] SWB_OFF_WORK   = 12'h040;
  localparam logic [11:0] SWB_OFF_DMEM   = 12'h100;
  localparam logic [5:0]  SWB_WORK_PAGE  = 6'h01;

  // --------------------------------------------------------------------------
  // Status bit positions and reset values
  // --------------------------------------------------------------------------
  localparam int          SWB_SR_C       = 0;
  localparam int          SWB_SR_Z       = 1;
  localparam int          SWB_SR_VF      = 2;
  localparam int          SWB_SR_N       = 3;
  localparam int          SWB_SR_HC      = 8;
  localparam logic [15:0] SWB_WORD_RST   = 16'h0000;
  localparam logic [23:0] SWB_INSTR_RST  = 24'h000000;

  // --------------------------------------------------------------------------
  // Encoding
  // --------------------------------------------------------------------------
  localparam logic [4:0] SWB_OP_FWD      = 5'h0B;   // 0101 1
  localparam logic [4:0] SWB_OP_REV      = 5'h03;   // 0001 1
  localparam logic [8:0] SWB_OP_FILE_FWD = 9'h16B;  // 1011 0101 1
  localparam logic [8:0] SWB_OP_FILE_REV = 9'h17B;  // 1011 1101 1
  localparam logic [1:0] SWB_LIT_MARK    = 2'b11;
  localparam logic [3:0] SWB_WORK_IDX    = 4'h0;

  localparam logic [2:0] SWB_AM_DIRECT   = 3'b000;
  localparam logic [2:0] SWB_AM_IND      = 3'b001;
  localparam logic [2:0] SWB_AM_POSTDEC  = 3'b010;
  localparam logic [2:0] SWB_AM_POSTINC  = 3'b011;
  localparam logic [2:0] SWB_AM_PREDEC   = 3'b100;
  localparam logic [2:0] SWB_AM_PREINC   = 3'b101;

  localparam logic [15:0] SWB_STEP_BYTE  = 16'h0001;
  localparam logic [15:0] SWB_STEP_WORD  = 16'h0002;

  typedef enum logic [4:0] {
    SWB_K_NONE     = 5'b00001,
    SWB_K_FWD      = 5'b00010,
    SWB_K_REV      = 5'b00100,
    SWB_K_FILE_FWD = 5'b01000,
    SWB_K_FILE_REV = 5'b10000
  } swb_kind_e;

  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
  } swb_flags_s;

  typedef struct packed {
    swb_kind_e   kind;
    logic        lit;
    logic        byte_op;
    logic        dst_file;
    logic [3:0]  wb;
    logic [3:0]  ws;
    logic [3:0]  wd;
    logic [2:0]  qmode;
    logic [2:0]  pmode;
    logic [4:0]  klit;
    logic [12:0] faddr;
  } swb_dec_s;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] ptr;
  } swb_ea_s;

  // --------------------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------------------
  function automatic swb_dec_s swb_decode(input logic [23:0] iw);
    swb_dec_s d;
    d.kind     = SWB_K_NONE;
    d.byte_op  = iw[14];
    d.wb       = iw[18:15];
    d.qmode    = iw[13:11];
    d.wd       = iw[10:7];
    d.pmode    = iw[6:4];
    d.ws       = iw[3:0];
    d.lit      = (iw[6:5] == SWB_LIT_MARK);
    d.klit     = iw[4:0];
    d.dst_file = iw[13];
    d.faddr    = iw[12:0];
    if (iw[23:19] == SWB_OP_FWD) begin
      d.kind = SWB_K_FWD;
    end else if (iw[23:19] == SWB_OP_REV) begin
      d.kind = SWB_K_REV;
    end else if (iw[23:15] == SWB_OP_FILE_FWD) begin
      d.kind = SWB_K_FILE_FWD;
    end else if (iw[23:15] == SWB_OP_FILE_REV) begin
      d.kind = SWB_K_FILE_REV;
    end
    return d;
  endfunction : swb_decode

  // Effective address and updated pointer of an addressing mode
  function automatic swb_ea_s swb_ea(input logic [15:0] ptr, input logic [2:0] mode,
                                     input logic byte_op);
    swb_ea_s     r;
    logic [15:0] step;
    step  = byte_op ? SWB_STEP_BYTE : SWB_STEP_WORD;
    r.ea  = ptr;
    r.ptr = ptr;
    unique case (mode)
      SWB_AM_POSTDEC: r.ptr = ptr - step;
      SWB_AM_POSTINC: r.ptr = ptr + step;
      SWB_AM_PREDEC: begin
        r.ptr = ptr - step;
        r.ea  = ptr - step;
      end
      SWB_AM_PREINC: begin
        r.ptr = ptr + step;
        r.ea  = ptr + step;
      end
      default: r.ptr = ptr;
    endcase
    return r;
  endfunction : swb_ea

  // Byte operations replace the low byte only
  function automatic logic [15:0] swb_lane(input logic [15:0] old, input logic [15:0] val,
                                           input logic byte_op);
    return byte_op ? {old[15:8], val[7:0]} : val;
  endfunction : swb_lane

  function automatic logic [31:0] swb_be_merge(input logic [31:0] old, input logic [31:0] val,
                                               input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction : swb_be_merge

endpackage : swb_pkg

/* File: verilog/swb_alu.sv */
// Borrow-chained subtractor with status flag generation
`timescale 1ns/1ps
module swb_alu
  import swb_pkg::*;
(
  input  wire logic [15:0] A,
  input  wire logic [15:0] B,
  input  wire logic        CIN,
  input  wire logic        BYTE_OP,
  output logic      [15:0] RES,
  output swb_flags_s       FLAGS
);

  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic [4:0]  sum_n;
  logic        msb_a;
  logic        msb_b;

  // A + ~B + C is A - B - borrow
  always_comb begin
    sum_w    = {1'b0, A} + {1'b0, ~B} + {16'h0000, CIN};
    sum_b    = {1'b0, A[7:0]} + {1'b0, ~B[7:0]} + {8'h00, CIN};
    sum_n    = {1'b0, A[3:0]} + {1'b0, ~B[3:0]} + {4'h0, CIN};
    RES      = BYTE_OP ? {8'h00, sum_b[7:0]} : sum_w[15:0];
    msb_a    = BYTE_OP ? A[7] : A[15];
    msb_b    = BYTE_OP ? B[7] : B[15];
    FLAGS.c  = BYTE_OP ? sum_b[8] : sum_w[16];
    FLAGS.dc = sum_n[4];
    FLAGS.n  = BYTE_OP ? sum_b[7] : sum_w[15];
    FLAGS.ov = (msb_a ^ msb_b) & (msb_a ^ FLAGS.n);
    FLAGS.z  = BYTE_OP ? (sum_b[7:0] == 8'h00) : (sum_w[15:0] == 16'h0000);
  end

endmodule : swb_alu

/* File: verilog/swb_unit.sv */
// Subtract-with-borrow execute unit with Avalon-MM register access
`timescale 1ns/1ps
// Function
// - Forward literal: base minus literal minus borrow
// - Forward reg form: base minus source minus borrow
// - Reverse file form: W0 minus file minus borrow
// - Destination bit: 0 to W0, 1 to file
// - Default work register is working register zero
// - Reverse literal: literal minus base minus borrow
// - Reverse literal prefix 0001 1, pattern 11
// - Reverse reg form: source minus base minus borrow
// - Width bit: 0 word, 1 byte; C, N, OV, Z follow, half-carry always from bit 3
// - Zero flag sticky: instructions only ever clear it; a status write can set it
// - Update half-carry, N, wrap, Z, C; borrow not-C
// - Base direct; source/destination direct or indirect
// - q/p modes, d/s registers decoded from fields
// - Literal zero-extended to operation width
// - Forward literal prefix 0101 1, pattern 11
module swb_unit
  import swb_pkg::*;
#(
  parameter int DMEM_WORDS = 64
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [11:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST
);

  localparam int IDXW = $clog2(DMEM_WORDS);

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  generate
    if (DMEM_WORDS < 2 || DMEM_WORDS > 512 || (DMEM_WORDS & (DMEM_WORDS - 1)) != 0) begin : g_chk
      $error("DMEM_WORDS must be a power of two from 2 to 512");
    end
  endgenerate

  typedef logic [DMEM_WORDS-1:0][15:0] swb_mem_t;

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic [23:0]      instr;
    logic [15:0]      result;
    logic             illegal;
    swb_flags_s       flags;
    logic [15:0][15:0] default_work_reg;
    swb_mem_t         dmem;
  } swb_state_s;

  swb_state_s  s_q;
  swb_state_s  s_d;

  // --------------------------------------------------------------------------
  // Data memory helpers
  // --------------------------------------------------------------------------
  function automatic logic [IDXW-1:0] mem_idx(input logic [15:0] addr);
    return addr[IDXW:1];
  endfunction : mem_idx

  function automatic logic [15:0] mem_rd(input swb_mem_t mem, input logic [15:0] addr,
                                         input logic byte_op);
    logic [15:0] w;
    w = mem[mem_idx(addr)];
    if (!byte_op) begin
      return w;
    end
    return addr[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction : mem_rd

  function automatic logic [15:0] mem_merge(input logic [15:0] old, input logic [15:0] addr,
                                            input logic [15:0] val, input logic byte_op);
    if (!byte_op) begin
      return val;
    end
    return addr[0] ? {val[7:0], old[7:0]} : {old[15:8], val[7:0]};
  endfunction : mem_merge

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic        req;
  logic        wr_acc;
  logic        exec;
  logic [11:0] drel;
  logic        in_default_work_reg;
  logic        in_dmem;
  logic [IDXW-1:0] dword;
  logic [31:0] instr_m;
  logic [31:0] rd_mux;

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~s_q.ack;
  assign AVS_READDATA    = s_q.rdata;
  assign wr_acc          = AVS_WRITE & s_q.ack;
  assign exec            = wr_acc & (AVS_ADDRESS[11:2] == SWB_OFF_INSTR[11:2]);
  assign drel            = AVS_ADDRESS - SWB_OFF_DMEM;
  assign in_default_work_reg         = (AVS_ADDRESS[11:6] == SWB_WORK_PAGE);
  assign in_dmem         = (AVS_ADDRESS >= SWB_OFF_DMEM) && (drel[11:2] < 10'(DMEM_WORDS));
  assign dword           = drel[IDXW+1:2];
  assign instr_m         = swb_be_merge({8'h00, s_q.instr}, AVS_WRITEDATA, AVS_BYTEENABLE);

  always_comb begin
    rd_mux = 32'h00000000;
    if (AVS_ADDRESS[11:2] == SWB_OFF_INSTR[11:2]) begin
      rd_mux = {8'h00, s_q.instr};
    end else if (AVS_ADDRESS[11:2] == SWB_OFF_STATUS[11:2]) begin
      rd_mux[SWB_SR_C]  = s_q.flags.c;
      rd_mux[SWB_SR_Z]  = s_q.flags.z;
      rd_mux[SWB_SR_VF] = s_q.flags.ov;
      rd_mux[SWB_SR_N]  = s_q.flags.n;
      rd_mux[SWB_SR_HC] = s_q.flags.dc;
    end else if (AVS_ADDRESS[11:2] == SWB_OFF_RESULT[11:2]) begin
      rd_mux = {16'h0000, s_q.result};
    end else if (AVS_ADDRESS[11:2] == SWB_OFF_ERROR[11:2]) begin
      rd_mux = {31'h00000000, s_q.illegal};
    end else if (in_default_work_reg) begin
      rd_mux = {16'h0000, s_q.default_work_reg[AVS_ADDRESS[5:2]]};
    end else if (in_dmem) begin
      rd_mux = {16'h0000, s_q.dmem[dword]};
    end
  end

  // --------------------------------------------------------------------------
  // Operand selection
  // --------------------------------------------------------------------------
  swb_dec_s    dec;
  swb_ea_s     src_ea;
  swb_ea_s     dst_ea;
  logic [15:0] src_val;
  logic [15:0] file_val;
  logic [15:0] wb_val;
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [15:0] alu_res;
  swb_flags_s  alu_fl;
  logic        bad_mode;

  assign dec      = swb_decode(instr_m[23:0]);
  assign bad_mode = (dec.qmode > SWB_AM_PREINC);
  assign wb_val   = s_q.default_work_reg[dec.wb];
  assign src_ea   = swb_ea(s_q.default_work_reg[dec.ws], dec.pmode, dec.byte_op);
  assign dst_ea   = swb_ea(s_q.default_work_reg[dec.wd], dec.qmode, dec.byte_op);
  assign file_val = mem_rd(s_q.dmem, {3'b000, dec.faddr}, dec.byte_op);

  always_comb begin
    if (dec.lit) begin
      src_val = {11'h000, dec.klit};
    end else if (dec.pmode == SWB_AM_DIRECT) begin
      src_val = s_q.default_work_reg[dec.ws];
    end else begin
      src_val = mem_rd(s_q.dmem, src_ea.ea, dec.byte_op);
    end
  end

  always_comb begin
    alu_a = wb_val;
    alu_b = src_val;
    unique case (dec.kind)
      SWB_K_FWD: begin
        alu_a = wb_val;
        alu_b = src_val;
      end
      SWB_K_REV: begin
        alu_a = src_val;
        alu_b = wb_val;
      end
      SWB_K_FILE_FWD: begin
        alu_a = file_val;
        alu_b = s_q.default_work_reg[SWB_WORK_IDX];
      end
      SWB_K_FILE_REV: begin
        alu_a = s_q.default_work_reg[SWB_WORK_IDX];
        alu_b = file_val;
      end
      SWB_K_NONE: begin
        alu_a = wb_val;
        alu_b = src_val;
      end
    endcase
  end

  swb_alu u_alu (
    .A       (alu_a),
    .B       (alu_b),
    .CIN     (s_q.flags.c),
    .BYTE_OP (dec.byte_op),
    .RES     (alu_res),
    .FLAGS   (alu_fl)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    if (wr_acc) begin
      if (AVS_ADDRESS[11:2] == SWB_OFF_STATUS[11:2] && AVS_BYTEENABLE[0]) begin
        s_d.flags.c  = AVS_WRITEDATA[SWB_SR_C];
        s_d.flags.z  = AVS_WRITEDATA[SWB_SR_Z];
        s_d.flags.ov = AVS_WRITEDATA[SWB_SR_VF];
        s_d.flags.n  = AVS_WRITEDATA[SWB_SR_N];
      end
      if (AVS_ADDRESS[11:2] == SWB_OFF_STATUS[11:2] && AVS_BYTEENABLE[1]) begin
        s_d.flags.dc = AVS_WRITEDATA[SWB_SR_HC];
      end
      if (AVS_ADDRESS[11:2] == SWB_OFF_ERROR[11:2] && AVS_WRITEDATA[0] && AVS_BYTEENABLE[0]) begin
        s_d.illegal = 1'b0;
      end
      if (in_default_work_reg) begin
        s_d.default_work_reg[AVS_ADDRESS[5:2]] =
          16'(swb_be_merge({16'h0000, s_q.default_work_reg[AVS_ADDRESS[5:2]]}, AVS_WRITEDATA,
                           AVS_BYTEENABLE));
      end
      if (in_dmem) begin
        s_d.dmem[dword] = 16'(swb_be_merge({16'h0000, s_q.dmem[dword]}, AVS_WRITEDATA,
                                           AVS_BYTEENABLE));
      end
    end
    if (exec) begin
      s_d.instr = instr_m[23:0];
      if (dec.kind == SWB_K_NONE || (bad_mode && (dec.kind == SWB_K_FWD ||
                                                   dec.kind == SWB_K_REV))) begin
        s_d.illegal = 1'b1;
      end else begin
        s_d.illegal  = 1'b0;
        s_d.result   = alu_res;
        s_d.flags.c  = alu_fl.c;
        s_d.flags.dc = alu_fl.dc;
        s_d.flags.n  = alu_fl.n;
        s_d.flags.ov = alu_fl.ov;
        s_d.flags.z  = s_q.flags.z & alu_fl.z;
        if (dec.kind == SWB_K_FWD || dec.kind == SWB_K_REV) begin
          if (!dec.lit && dec.pmode != SWB_AM_DIRECT) begin
            s_d.default_work_reg[dec.ws] = src_ea.ptr;
          end
          if (dec.qmode == SWB_AM_DIRECT) begin
            s_d.default_work_reg[dec.wd] = swb_lane(s_q.default_work_reg[dec.wd], alu_res, dec.byte_op);
          end else begin
            s_d.default_work_reg[dec.wd] = dst_ea.ptr;
            s_d.dmem[mem_idx(dst_ea.ea)] =
              mem_merge(s_q.dmem[mem_idx(dst_ea.ea)], dst_ea.ea, alu_res, dec.byte_op);
          end
        end else if (dec.dst_file) begin
          s_d.dmem[mem_idx({3'b000, dec.faddr})] =
            mem_merge(s_q.dmem[mem_idx({3'b000, dec.faddr})], {3'b000, dec.faddr},
                      alu_res, dec.byte_op);
        end else begin
          s_d.default_work_reg[SWB_WORK_IDX] =
            swb_lane(s_q.default_work_reg[SWB_WORK_IDX], alu_res, dec.byte_op);
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : swb_unit

/* File: sim/swb_unit_sva.sv */
// Bus-side checker for the subtract-with-borrow unit
`timescale 1ns/1ps
module swb_unit_sva
  import swb_pkg::*;
(
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  logic req;
  logic rd_done;
  assign req     = AVS_READ | AVS_WRITE;
  assign rd_done = AVS_READ & ~AVS_WAITREQUEST;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST)
    else $error("waitrequest low in first request cycle");
  a_answer_next: assert property ((req && AVS_WAITREQUEST) ##1 req |-> !AVS_WAITREQUEST)
    else $error("answer not given after one wait cycle");
  a_idle_free: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("waitrequest high without request");
  a_ack_rearm: assert property ((req && !AVS_WAITREQUEST) ##1 req |-> AVS_WAITREQUEST)
    else $error("held request answered twice");
  a_rdata_hold: assert property (!req ##1 !req |-> $stable(AVS_READDATA))
    else $error("read data moved while idle");
  a_status_rsvd: assert property (rd_done && AVS_ADDRESS[11:2] == SWB_OFF_STATUS[11:2]
    |-> AVS_READDATA[31:9] == 23'h0 && AVS_READDATA[7:4] == 4'h0)
    else $error("status reserved bits set");
  a_result_width: assert property (rd_done && AVS_ADDRESS[11:2] == SWB_OFF_RESULT[11:2]
    |-> AVS_READDATA[31:16] == 16'h0)
    else $error("result wider than a word");
  a_default_work_reg_width: assert property (rd_done && AVS_ADDRESS[11:6] == SWB_WORK_PAGE
    |-> AVS_READDATA[31:16] == 16'h0)
    else $error("working register wider than a word");
  a_error_bits: assert property (rd_done && AVS_ADDRESS[11:2] == SWB_OFF_ERROR[11:2]
    |-> AVS_READDATA[31:1] == 31'h0)
    else $error("error register reserved bits set");
  a_unmapped_zero: assert property (rd_done && AVS_ADDRESS[11:6] == 6'h00
    && AVS_ADDRESS[5:4] != 2'h0 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
endmodule : swb_unit_sva

bind swb_unit swb_unit_sva swb_unit_sva_inst (
  .CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST)
);

/* File: sim/swb_host.sv */
// Avalon-MM master model standing in for the core side
`timescale 1ns/1ps
module swb_host (
  input  wire logic        clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [11:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  initial begin
    avs_address    = 12'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
  end

  // One access; held until waitrequest is seen low at an edge
  task automatic bus_access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            output logic [31:0] q);
    @(posedge clk);
    avs_address    <= a;
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= d;
    avs_byteenable <= 4'hF;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_access
endmodule : swb_host

/* File: sim/swb_unit_tb.sv */
// Self-checking testbench of the subtract-with-borrow unit
`timescale 1ns/1ps
module swb_unit_tb
  import swb_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] FLG = 32'h0000000F;
  logic        clk;
  logic        srst;
  logic [11:0] address;
  logic        rd_req;
  logic        wr_req;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;

  swb_unit #(.DMEM_WORDS(8)) swb_unit_inst (
    .CLK(clk), .SRST(srst), .AVS_ADDRESS(address), .AVS_READ(rd_req), .AVS_WRITE(wr_req),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq)
  );
  swb_host swb_host_inst (
    .clk(clk), .avs_readdata(rdata), .avs_waitrequest(waitreq), .avs_address(address),
    .avs_read(rd_req), .avs_write(wr_req), .avs_writedata(wdata), .avs_byteenable(be)
  );

  // --------------------------------------------------------------------------
  // Clock, reset, timeout
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic give_verdict();
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    swb_host_inst.bus_access(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    swb_host_inst.bus_access(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask : chk
  function automatic logic [11:0] wa(input int i);
    return SWB_OFF_WORK + 12'(4 * i);
  endfunction : wa
  function automatic logic [11:0] dm(input int i);
    return SWB_OFF_DMEM + 12'(4 * i);
  endfunction : dm

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    chk(SWB_OFF_STATUS, ALL, 32'h0);
    chk(SWB_OFF_RESULT, ALL, 32'h0);
    for (int i = 0; i < 16; i++) chk(wa(i), ALL, 32'h0);
    wr(12'h020, 32'hDEADBEEF);
    chk(12'h020, ALL, 32'h0);
    // Forward literal, byte
    wr(wa(4), 32'h1782);
    wr(wa(5), 32'h7804);
    wr(SWB_OFF_STATUS, 32'h0);
    wr(SWB_OFF_INSTR, 32'h005A42F0);
    chk(wa(5), ALL, 32'h7871);
    chk(SWB_OFF_STATUS, FLG, 32'h5);
    // Forward literal, word, post-increment destination
    wr(wa(0), 32'h0009);
    wr(wa(2), 32'h0004);
    wr(dm(2), 32'hA557);
    wr(SWB_OFF_STATUS, 32'h2);
    wr(SWB_OFF_INSTR, 32'h00581968);
    chk(dm(2), ALL, 32'h0);
    chk(wa(2), ALL, 32'h0006);
    chk(SWB_OFF_STATUS, ALL, 32'h103);
    // Forward register form, byte
    wr(wa(0), 32'h1732);
    wr(wa(1), 32'h7844);
    wr(SWB_OFF_STATUS, 32'h0);
    wr(SWB_OFF_INSTR, 32'h00584001);
    chk(wa(0), ALL, 32'h17ED);
    chk(SWB_OFF_RESULT, ALL, 32'h00ED);
    chk(SWB_OFF_STATUS, FLG, 32'h8);
    // Reverse register form, byte
    wr(wa(0), 32'h1732);
    wr(SWB_OFF_STATUS, 32'h0);
    wr(SWB_OFF_INSTR, 32'h00184001);
    chk(wa(0), ALL, 32'h1711);
    chk(SWB_OFF_STATUS, FLG, 32'h1);
    // Reverse file form, byte, odd address, to file
    wr(wa(0), 32'h7804);
    wr(dm(1), 32'h9439);
    wr(SWB_OFF_STATUS, 32'h2);
    wr(SWB_OFF_INSTR, 32'h00BDE003);
    chk(dm(1), ALL, 32'h6F39);
    chk(wa(0), ALL, 32'h7804);
    chk(SWB_OFF_STATUS, ALL, 32'h0);
    // Reverse file form, word, to working register zero
    wr(wa(0), 32'h6234);
    wr(dm(2), 32'h6235);
    wr(SWB_OFF_INSTR, 32'h00BD8004);
    chk(wa(0), ALL, 32'hFFFE);
    chk(dm(2), ALL, 32'h6235);
    chk(SWB_OFF_STATUS, ALL, 32'h8);
    // Reverse literal, byte, sticky zero kept
    wr(wa(0), 32'hF310);
    wr(wa(1), 32'h786A);
    wr(SWB_OFF_STATUS, 32'h3);
    wr(SWB_OFF_INSTR, 32'h001840F0);
    chk(wa(1), ALL, 32'h7800);
    chk(SWB_OFF_STATUS, ALL, 32'h103);
    // Reserved destination mode refused
    wr(SWB_OFF_INSTR, 32'h00587001);
    chk(SWB_OFF_ERROR, ALL, 32'h1);
    chk(wa(0), ALL, 32'hF310);
    chk(SWB_OFF_STATUS, ALL, 32'h103);
    wr(SWB_OFF_ERROR, 32'h1);
    chk(SWB_OFF_ERROR, ALL, 32'h0);
    give_verdict();
  end
endmodule : swb_unit_tb
